/* File: src/spi_frame_pkg.sv */
// Purpose: shared constants for the byte-wide serial port
// Assumes: registers sit on word-aligned APB addresses (index times four)
// Notes: printed offsets are kept as indices; byte address is derived
package spi_frame_pkg;

  // register indices as printed, and their APB byte addresses
  localparam logic [7:0] CTRL_IDX = 8'h10;
  localparam logic [7:0] STAT_IDX = 8'h11;
  localparam logic [7:0] DATA_IDX = 8'h12;
  localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
  localparam logic [7:0] DATA_ADDR = {DATA_IDX[5:0], 2'b00};

  // control_reg fields
  localparam int CTRL_RIE = 7;
  localparam int CTRL_MASTER = 5;
  localparam int CTRL_CPOL = 4;
  localparam int CTRL_CPHA = 3;
  localparam int CTRL_SPE = 1;
  localparam int CTRL_TIE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hbb;

  // status_and_control_reg fields
  localparam int STAT_RXFULL = 7;
  localparam int STAT_ERROR_INTERRUPT_ENABLE = 6;
  localparam int STAT_OVERFLOW_FLAG = 5;
  localparam int STAT_MODE_FAULT_FLAG = 4;
  localparam int STAT_TXEMPTY = 3;
  localparam int STAT_MODE_FAULT_DETECT_ENABLE = 2;
  localparam int STAT_RATE_HI = 1;
  localparam int STAT_RATE_LO = 0;

  // rate field codes and divider lengths in bus cycles
  localparam logic [1:0] RATE_DIVIDE_BY_TWO_RATE = 2'h0;
  localparam logic [1:0] RATE_DIVIDE_BY_EIGHT_RATE = 2'h1;
  localparam logic [1:0] RATE_DIVIDE_BY_THIRTY_TWO_RATE = 2'h2;
  localparam logic [1:0] RATE_DIVIDE_BY_ONE_TWENTY_EIGHT_RATE = 2'h3;
  localparam logic [7:0] DIVIDE_BY_TWO_RATE_CYCLES = 8'h02;
  localparam logic [7:0] DIVIDE_BY_EIGHT_RATE_CYCLES = 8'h08;
  localparam logic [7:0] DIVIDE_BY_THIRTY_TWO_RATE_CYCLES = 8'h20;
  localparam logic [7:0] DIVIDE_BY_ONE_TWENTY_EIGHT_RATE_CYCLES = 8'h80;

  // sixteen clock edges make one byte
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  // transfer state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } xfer_state_t;

endpackage

/* File: src/pin_sync.sv */
// Purpose: two-stage synchroniser for pins entering the bus clock domain
// Assumes: the first stage is read only by the second
// Notes: reset value chosen per bit so idle pins look idle
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // pins in, synchronised copy out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  // double register against metastability
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta <= INIT;
      q_out <= INIT;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

/* File: src/spi_frame.sv */
// Purpose: byte serial port, master or slave, with APB registers
// Assumes: APB with zero wait states; pins sampled on the bus clock
// Notes: a slave link clock must stay well below the bus clock
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module spi_frame
  import spi_frame_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // serial link pins
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  input wire logic SS_N_IN,
  // interrupt requests
  output logic RX_IRQ_OUT,
  output logic TX_IRQ_OUT
);

  logic rst_meta;
  logic rst_n;
  logic [3:0] pin_q;
  logic sck_s, mosi_s, miso_s, ss_s;
  logic sck_prev, ss_prev;
  logic [7:0] ctrl;
  logic error_interrupt_enable, mode_fault_detect_enable;
  logic [1:0] rate;
  logic [7:0] tx_buf, shreg, rx_data;
  logic tx_full, rx_full, overflow_flag, drop, rd_armed, overflow_flag_armed;
  logic sample_bit, sck_act;
  logic [4:0] ecnt, next_ecnt;
  logic [6:0] div_cnt, div_last, half_last;
  logic [7:0] wait_cnt;
  xfer_state_t state;
  logic port_enable_bit, cpol, cpha, master_on, slave_on, running;
  logic half_tick, boundary, m_start, s_start, m_edge, s_edge, edge_ev;
  logic sample_now, shift_now, first_sample, done, din, load_shift;
  logic wr, rd, hit;
  logic [7:0] rd_mux;

  // reset released through two flops
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pins cross into the bus clock domain; select idles high
  pin_sync #(.W(4), .INIT(4'h1)) u_pin_sync (
    .clk_in(CLOCK_IN),
    .rstn_in(rst_n),
    .d_in({SCK_IN, MOSI_IN, MISO_IN, SS_N_IN}),
    .q_out(pin_q)
  );
  assign sck_s = pin_q[3];
  assign mosi_s = pin_q[2];
  assign miso_s = pin_q[1];
  assign ss_s = pin_q[0];

  // decoded control
  assign port_enable_bit = ctrl[CTRL_SPE];
  assign cpol = ctrl[CTRL_CPOL];
  assign cpha = ctrl[CTRL_CPHA];
  assign master_on = port_enable_bit & ctrl[CTRL_MASTER];
  assign slave_on = port_enable_bit & ~ctrl[CTRL_MASTER];
  assign running = (state == ST_RUN);

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign hit = (PADDR_IN == CTRL_ADDR) | (PADDR_IN == STAT_ADDR) | (PADDR_IN == DATA_ADDR);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;

  // read mux; modes fault detection is not built here, so its flag reads zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (PADDR_IN == CTRL_ADDR)
      rd_mux = ctrl;
    else if (PADDR_IN == STAT_ADDR)
      rd_mux = {rx_full, error_interrupt_enable, overflow_flag, 1'b0, ~tx_full, mode_fault_detect_enable, rate};
    else if (PADDR_IN == DATA_ADDR)
      rd_mux = rx_data;
  end

  // read data captured in the setup cycle, shown during access
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      PRDATA_OUT <= 32'h0;
    else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN)
      PRDATA_OUT <= {24'h0, rd_mux};
  end

  // control register; software clears enable before changing polarity/phase
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else if (wr & (PADDR_IN == CTRL_ADDR))
      ctrl <= PWDATA_IN[7:0] & CTRL_WMASK;
  end

  // writable status bits
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_interrupt_enable <= 1'b0;
      mode_fault_detect_enable <= 1'b0;
      rate <= RATE_DIVIDE_BY_TWO_RATE;
    end
    else if (wr & (PADDR_IN == STAT_ADDR))
    begin
      error_interrupt_enable <= PWDATA_IN[STAT_ERROR_INTERRUPT_ENABLE];
      mode_fault_detect_enable <= PWDATA_IN[STAT_MODE_FAULT_DETECT_ENABLE];
      rate <= PWDATA_IN[STAT_RATE_HI:STAT_RATE_LO];
    end
  end

  // divider length from the rate field
  always_comb
  begin
    unique case (rate)
      RATE_DIVIDE_BY_TWO_RATE: div_last = 7'(DIVIDE_BY_TWO_RATE_CYCLES - 8'h01);
      RATE_DIVIDE_BY_EIGHT_RATE: div_last = 7'(DIVIDE_BY_EIGHT_RATE_CYCLES - 8'h01);
      RATE_DIVIDE_BY_THIRTY_TWO_RATE: div_last = 7'(DIVIDE_BY_THIRTY_TWO_RATE_CYCLES - 8'h01);
      RATE_DIVIDE_BY_ONE_TWENTY_EIGHT_RATE: div_last = 7'(DIVIDE_BY_ONE_TWENTY_EIGHT_RATE_CYCLES - 8'h01);
    endcase
    half_last = 7'(div_last >> 1);
  end

  // free-running divider, held at zero to save power when not master
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 7'h00;
    else if (!master_on || div_cnt == div_last)
      div_cnt <= 7'h00;
    else
      div_cnt <= div_cnt + 7'h01;
  end

  // link edges fall on bus clock edges, one per half bit time
  assign half_tick = master_on & ((div_cnt == half_last) | (div_cnt == div_last));
  assign boundary = master_on & (div_cnt == div_last);

  // master starts at the next bit boundary after a data write
  assign m_start = master_on & ~running & tx_full & boundary;

  // slave start: select fall for phase 0, first leading edge for phase 1
  assign s_start = slave_on & ~running & ~ss_s &
                   (cpha ? (sck_s != sck_prev) & (sck_s != cpol) : ss_prev);

  // edge events; the master ignores its own select input
  assign m_edge = master_on & running & half_tick;
  assign s_edge = slave_on & running & ~ss_s & (sck_s != sck_prev);
  assign edge_ev = m_edge | s_edge;
  assign next_ecnt = ecnt + 5'h01;
  assign sample_now = edge_ev & (next_ecnt[0] ^ cpha);
  assign shift_now = edge_ev & ~(next_ecnt[0] ^ cpha);
  assign first_sample = sample_now & (next_ecnt == (cpha ? 5'h02 : 5'h01));
  assign done = edge_ev & (next_ecnt == EDGES_PER_BYTE);
  assign din = ctrl[CTRL_MASTER] ? miso_s : mosi_s;

  // buffer moves to the shifter only while idle
  assign load_shift = tx_full & (m_start | (slave_on & ~running));

  // previous pin levels for edge detection
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_prev <= 1'b0;
      ss_prev <= 1'b1;
    end
    else
    begin
      sck_prev <= sck_s;
      ss_prev <= ss_s;
    end
  end

  // transfer state; a select rise aborts a slave byte
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else if (!port_enable_bit)
      state <= ST_IDLE;
    else if (m_start | s_start)
      state <= ST_RUN;
    else if (done | (slave_on & ss_s))
      state <= ST_IDLE;
  end

  // edge counter; phase 1 counts the starting edge as the first
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      ecnt <= 5'h00;
    else if (m_start | s_start)
      ecnt <= cpha ? 5'h01 : 5'h00;
    else if (edge_ev)
      ecnt <= next_ecnt;
  end

  // master clock: phase 0 holds inactive for the first half cycle
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      sck_act <= 1'b0;
    else if (m_start)
      sck_act <= cpha;
    else if (m_edge)
      sck_act <= ~sck_act;
    else if (!running)
      sck_act <= 1'b0;
  end

  // transmit buffer; a write while busy waits for the byte end
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end
    else if (wr & (PADDR_IN == DATA_ADDR))
    begin
      tx_buf <= PWDATA_IN[7:0];
      tx_full <= 1'b1;
    end
    else if (!port_enable_bit | load_shift)
      tx_full <= 1'b0;
  end

  // shifter: MSB out first, captured bit enters at the bottom
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      shreg <= 8'h00;
    else if (!port_enable_bit)
      shreg <= 8'h00;
    else if (load_shift)
      shreg <= tx_buf;
    else if (shift_now)
      shreg <= {shreg[6:0], sample_bit};
  end

  // captured bit waits for the following shift edge
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      sample_bit <= 1'b0;
    else if (sample_now)
      sample_bit <= din;
  end

  // byte dropped when the previous one was unread at the first capture
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      drop <= 1'b0;
    else if (m_start | s_start)
      drop <= 1'b0;
    else if (first_sample & rx_full)
      drop <= 1'b1;
  end

  // receive register keeps the unread byte on overflow
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      rx_data <= 8'h00;
    else if (done & ~drop)
      rx_data <= cpha ? {shreg[6:0], din} : {shreg[6:0], sample_bit};
  end

  // clear sequence arming; overflow clears only if it was seen set
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_armed <= 1'b0;
      overflow_flag_armed <= 1'b0;
    end
    else if (rd & (PADDR_IN == STAT_ADDR))
    begin
      rd_armed <= 1'b1;
      overflow_flag_armed <= overflow_flag;
    end
    else if (rd & (PADDR_IN == DATA_ADDR))
    begin
      rd_armed <= 1'b0;
      overflow_flag_armed <= 1'b0;
    end
  end

  // receive-full flag; a new byte wins over a clearing read
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      rx_full <= 1'b0;
    else if (done & ~drop)
      rx_full <= 1'b1;
    else if (rd & (PADDR_IN == DATA_ADDR) & rd_armed)
      rx_full <= 1'b0;
  end

  // overflow flag; setting wins over clearing
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      overflow_flag <= 1'b0;
    else if (first_sample & rx_full)
      overflow_flag <= 1'b1;
    else if (rd & (PADDR_IN == DATA_ADDR) & overflow_flag_armed)
      overflow_flag <= 1'b0;
  end

  // pins: slave data only while selected, so one slave drives at a time
  assign SCK_OUT = cpol ^ sck_act;
  assign SCK_OE_OUT = master_on;
  assign MOSI_OUT = shreg[7];
  assign MOSI_OE_OUT = master_on;
  assign MISO_OUT = shreg[7];
  assign MISO_OE_OUT = slave_on & ~ss_s;

  // shared receive/error request; overflow masks the receive-full path
  assign RX_IRQ_OUT = ctrl[CTRL_RIE] & ((rx_full & ~overflow_flag & port_enable_bit) | (error_interrupt_enable & overflow_flag));
  assign TX_IRQ_OUT = ctrl[CTRL_TIE] & ~tx_full;

  // cycles a queued master byte has waited, watched below
  always_ff @(posedge CLOCK_IN or negedge rst_n)
  begin
    if (!rst_n)
      wait_cnt <= 8'h00;
    else if (master_on & ~running & tx_full)
      wait_cnt <= wait_cnt + 8'h01;
    else
      wait_cnt <= 8'h00;
  end

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!rst_n);

  // checked against the select pin itself, two bus cycles back through the synchroniser
  a_miso_select: assert property (MISO_OE_OUT |-> !$past(SS_N_IN, 2) && port_enable_bit && !ctrl[CTRL_MASTER])
    else $error("data out driven while slave not selected");

  a_start_delay: assert property (wait_cnt <= 8'(div_last) + 8'h01)
    else $error("master start later than one bit time");

  a_busy_noload: assert property (running && port_enable_bit |=> !$fell(tx_full))
    else $error("transmit buffer moved during a transfer");

  a_overflow_flag_set: assert property (first_sample && rx_full |=> overflow_flag && drop)
    else $error("overflow not flagged on unread byte");

  a_rx_keep: assert property (done && drop |=> $stable(rx_data) && rx_full)
    else $error("unread byte overwritten");

  a_err_irq: assert property (overflow_flag && error_interrupt_enable && ctrl[CTRL_RIE] |-> RX_IRQ_OUT)
    else $error("overflow request missing");

  a_rx_mask: assert property (overflow_flag && !error_interrupt_enable |-> !RX_IRQ_OUT)
    else $error("receive-full request while overflow set");

  // half a bit is one bus cycle at divide by two, longer at the slower rates
  a_phase0_first: assert property (m_start && !cpha |=> !sck_act ##1 (sck_act == (rate == RATE_DIVIDE_BY_TWO_RATE)))
    else $error("phase 0 clock left idle too early");

  a_phase1_first: assert property (m_start && cpha |=> sck_act)
    else $error("phase 1 first edge missing");

  a_div_gated: assert property (!master_on |=> div_cnt == 7'h00)
    else $error("divider ran while not master");

  a_rx_clear: assert property (rd && PADDR_IN == DATA_ADDR && rd_armed && !done
                               |=> !rx_full)
    else $error("receive-full not cleared by read sequence");

endmodule

/* File: testbench/spi_peer.sv */
// Purpose: behavioural peer slave on the serial link
// Assumes: always selected while the master drives the clock
// Notes: answers 3c first, then adds 11 per byte
`timescale 1ns/1ps
module spi_peer (
  // link from the master
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic en_in,
  // mode chosen by the bench
  input wire logic cpol_in,
  input wire logic cpha_in,
  // answer and last byte taken
  output logic miso_out,
  output logic [7:0] got_out
);
  logic [7:0] tx = 8'h3c;
  logic [7:0] sh = 8'h00;
  int n = 0;

  initial miso_out = 1'b0;
  initial got_out = 8'h00;

  // a disabled master drops the frame, so restart it cleanly
  always @(negedge en_in)
  begin
    n = 0;
    miso_out = tx[7];
  end

  // lead edge samples in phase 0, trail edge in phase 1
  always @(sck_in)
  begin
    if (!en_in)
      n = n;
    else if ((sck_in != cpol_in) ^ cpha_in)
    begin
      sh = {sh[6:0], mosi_in};
      n = n + 1;
      if (n == 8)
      begin
        got_out = sh;
        n = 0;
        tx = tx + 8'h11;
      end
    end
    else
      miso_out = tx[7 - n];
  end
endmodule

/* File: testbench/testbench.sv */
// Purpose: register and link checks of the byte serial port
// Assumes: zero wait APB; peer model answers in master mode
// Notes: bench plays the master itself when the port is a slave
`timescale 1ns/1ps
module testbench
  import spi_frame_pkg::*;
;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sck = 0, mosi = 0, ss_n = 1, pcpol = 0, pcpha = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, peer_miso;
  logic miso_out, miso_oe, rx_irq, tx_irq, err, sck_w, mosi_w, miso_w;
  logic [7:0] got, rx, ctl, ex;
  int failures = 0, cmp_count = 0, k = 0, n, dv;

  always #10 clk = ~clk;

  // wire levels from the port's enables; bench or peer drives otherwise
  assign sck_w = sck_oe ? sck_out : sck;
  assign mosi_w = mosi_oe ? mosi_out : mosi;
  assign miso_w = miso_oe ? miso_out : peer_miso;

  spi_frame u_dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCK_IN(sck_w),
    .SCK_OUT(sck_out), .SCK_OE_OUT(sck_oe), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_out),
    .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso_w), .MISO_OUT(miso_out),
    .MISO_OE_OUT(miso_oe), .SS_N_IN(ss_n), .RX_IRQ_OUT(rx_irq), .TX_IRQ_OUT(tx_irq));

  spi_peer u_peer (.sck_in(sck_w), .mosi_in(mosi_w), .en_in(sck_oe),
    .cpol_in(pcpol), .cpha_in(pcpha), .miso_out(peer_miso), .got_out(got));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp_v);
    cmp_count++;
    if (seen !== exp_v)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp_v, seen);
      failures++;
    end
  endtask

  task stop_test;
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bench as link master, 160 ns clock period, clock polarity 0
  task sl_byte(input logic ph, input logic [7:0] tx);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("miso drive", 32'(miso_oe), 32'h1);
    for (int b = 7; b >= 0; b--)
    begin
      if (!ph) mosi <= tx[b];
      repeat (4) @(posedge clk);
      if (!ph) rx[b] = miso_w;
      sck <= 1'b1;
      if (ph) mosi <= tx[b];
      repeat (4) @(posedge clk);
      if (ph) rx[b] = miso_w;
      sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, CTRL_ADDR, 8'h00);
    chk("ctrl reset", rd, {24'h0, CTRL_RESET});
    apb(0, STAT_ADDR, 8'h00);
    chk("stat reset", rd, 32'h08);
    apb(0, 8'h4c, 8'h00);
    chk("unmapped err", 32'(err), 32'h1);
    // every polarity/phase pair, each with its own rate code
    for (int i = 0; i < 4; i++)
    begin
      dv = 2 << (2 * i);
      ctl = {3'b101, i[1], i[0], 3'b000};
      apb(1, CTRL_ADDR, ctl);
      sck <= i[1];
      pcpol = i[1];
      pcpha = i[0];
      @(negedge clk);
      chk("clock off", 32'(sck_oe), 32'h0);
      apb(1, STAT_ADDR, {6'h0, i[1:0]});
      apb(1, CTRL_ADDR, ctl | 8'h02);
      @(negedge clk);
      chk("idle clock", 32'(sck_w), 32'(i[1]));
      chk("master miso", 32'(miso_oe), 32'h0);
      apb(1, DATA_ADDR, 8'ha5 ^ 8'(i));
      for (n = 0; rx_irq !== 1'b1 && n < 2000; n++) @(negedge clk);
      chk("start delay", 32'(n >= 8 * dv && n <= 9 * dv + 4), 32'h1);
      apb(0, STAT_ADDR, 8'h00);
      apb(0, DATA_ADDR, 8'h00);
      ex = 8'h3c + 8'h11 * 8'(k);
      // divide by two outruns the input synchroniser
      if (i != 0) chk("rx byte", rd, {24'h0, ex});
      chk("peer byte", {24'h0, got}, 32'h0a5 ^ 32'(i));
      @(negedge clk);
      chk("full cleared", 32'(rx_irq), 32'h0);
      k++;
    end
    // second byte lands on an unread one
    apb(1, DATA_ADDR, 8'h01);
    for (n = 0; rx_irq !== 1'b1 && n < 2000; n++) @(negedge clk);
    apb(1, DATA_ADDR, 8'h02);
    repeat (9 * 128 + 8) @(posedge clk);
    chk("full irq held", 32'(rx_irq), 32'h0);
    apb(1, STAT_ADDR, 8'h43);
    @(negedge clk);
    chk("error irq", 32'(rx_irq), 32'h1);
    apb(0, STAT_ADDR, 8'h00);
    chk("ovf status", rd, 32'heb);
    apb(0, DATA_ADDR, 8'h00);
    chk("kept byte", rd, {24'h0, 8'h3c + 8'h11 * 8'(k)});
    apb(0, STAT_ADDR, 8'h00);
    chk("ovf cleared", rd, 32'h4b);
    // slave, phase 0: late write waits for the byte end
    apb(1, CTRL_ADDR, 8'h00);
    sck <= 1'b0;
    // transmit-empty request on, so the held buffer shows on its pin
    apb(1, CTRL_ADDR, 8'h03);
    apb(1, DATA_ADDR, 8'h96);
    fork
      sl_byte(0, 8'h5a);
      begin
        repeat (30) @(posedge clk);
        apb(1, DATA_ADDR, 8'h11);
        @(negedge clk);
        chk("tx irq busy", 32'(tx_irq), 32'h0);
      end
    join
    chk("slave tx", {24'h0, rx}, 32'h96);
    chk("tx irq empty", 32'(tx_irq), 32'h1);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("miso release", 32'(miso_oe), 32'h0);
    apb(0, STAT_ADDR, 8'h00);
    apb(0, DATA_ADDR, 8'h00);
    chk("slave rx", rd, 32'h5a);
    sl_byte(0, 8'hc3);
    chk("queued tx", {24'h0, rx}, 32'h11);
    ss_n <= 1'b1;
    // drain it, or the next byte would land on an unread one
    apb(0, STAT_ADDR, 8'h00);
    apb(0, DATA_ADDR, 8'h00);
    chk("queued rx", rd, 32'hc3);
    // slave, phase 1: select stays low across two bytes
    apb(1, CTRL_ADDR, 8'h08);
    apb(1, CTRL_ADDR, 8'h0a);
    apb(1, DATA_ADDR, 8'h77);
    sl_byte(1, 8'he1);
    chk("phase1 tx", {24'h0, rx}, 32'h77);
    apb(0, STAT_ADDR, 8'h00);
    apb(0, DATA_ADDR, 8'h00);
    chk("phase1 rx", rd, 32'he1);
    sl_byte(1, 8'h3d);
    apb(0, STAT_ADDR, 8'h00);
    apb(0, DATA_ADDR, 8'h00);
    chk("held select rx", rd, 32'h3d);
    stop_test;
  end

  // about five times the expected run length
  initial
  begin
    #400000;
    failures++;
    stop_test;
  end
endmodule
